// >>> include/dag_regs.vh
/*
  Constants for the data address generator: page-zero map, field layouts,
  reset values, address-mode encodings and aux-unit operation encodings.
  Assumes it is included by bare name from the design files.
*/
// Contract
// - Direct address is page pointer over offset.
// - Page pointer picks 512 pages of 128.
// - Memory-mapped mode forces upper nine bits zero.
// - Indirect uses selected aux register on bus.
// - One operand on first bus, second on program.
// - Long immediate address from word at pc.
// - Block-move register addresses the second operand.
// - Two circular buffers with start and end.
// - Repeat-single ops load the single repeat count.
// - Block repeat loads start, end; count rewritable.
// - Memory wait counts for four 16K blocks.
// - I/O wait counts for eight partitions.
// - Wait control picks 0-3 or 0,1,3,7 sets.
// - Partition bit: port pairs or 8K blocks.
// - Addresses 50h-5Fh become I/O port accesses.
// - 32-word scratch RAM reachable by all modes.
// - Temps give shift count and bit index.
// - Global overlay register sizes global overlay.
// - 0-4Fh registers, 50-5Fh I/O window decode.
`ifndef DAG_REGS_VH
`define DAG_REGS_VH

`define DAG_MODE_DIRECT 3'h0
`define DAG_MODE_MMAP 3'h1
`define DAG_MODE_INDIRECT 3'h2
`define DAG_MODE_LONG 3'h3
`define DAG_MODE_BLOCK 3'h4

`define DAG_OFS_GLOBAL 7'h05
`define DAG_OFS_SREP 7'h08
`define DAG_OFS_BREP 7'h09
`define DAG_OFS_BSTART 7'h0a
`define DAG_OFS_BEND 7'h0b
`define DAG_OFS_TEMP0 7'h0c
`define DAG_OFS_TEMP1 7'h0d
`define DAG_OFS_TEMP2 7'h0e
`define DAG_OFS_AUX0 7'h10
`define DAG_OFS_INDEX 7'h18
`define DAG_OFS_C1START 7'h1a
`define DAG_OFS_C1END 7'h1b
`define DAG_OFS_C2START 7'h1c
`define DAG_OFS_C2END 7'h1d
`define DAG_OFS_CCTRL 7'h1e
`define DAG_OFS_BMOVE 7'h1f
`define DAG_OFS_MEMWAIT 7'h28
`define DAG_OFS_IOWAIT 7'h29
`define DAG_OFS_WAITCTL 7'h2a
`define DAG_OFS_REG_LAST 7'h4f
`define DAG_OFS_IO_FIRST 7'h50
`define DAG_OFS_IO_LAST 7'h5f
`define DAG_OFS_SCR_FIRST 7'h60

`define DAG_CC_CAR1_LSB 0
`define DAG_CC_EN1_BIT 3
`define DAG_CC_CAR2_LSB 4
`define DAG_CC_EN2_BIT 7
`define DAG_WC_SET_BIT 0
`define DAG_WC_BIG_BIT 1

`define DAG_RST_WORD 16'h0000
`define DAG_RST_WAIT 16'hffff
`define DAG_RST_WAITCTL 16'h0000

`define DAG_AUX_ARITH_UNIT_NONE 3'h0
`define DAG_AUX_ARITH_UNIT_INC 3'h1
`define DAG_AUX_ARITH_UNIT_DEC 3'h2
`define DAG_AUX_ARITH_UNIT_ADDX 3'h3
`define DAG_AUX_ARITH_UNIT_SUBX 3'h4

`endif

// >>> rtl/dag_circ_unit.v
/*
  Circular-buffer update for one buffer: wraps a stepped auxiliary value
  to the start address when the current value sits on the end address.
  Assumes the caller supplies the buffer's registers and the selected index.
*/
`timescale 1ns/10ps
module dag_circ_unit (
  input wire enable,
  input wire [2:0] aux_sel,
  input wire [2:0] buf_aux,
  input wire [15:0] cur_val,
  input wire [15:0] step_val,
  input wire [15:0] start_addr,
  input wire [15:0] end_addr,
  output wire hit,
  output wire [15:0] wrapped
);
  assign hit = enable && (aux_sel == buf_aux) && (cur_val == end_addr);
  assign wrapped = hit ? start_addr : step_val;
endmodule

// >>> rtl/dag_wait_sel.v
/*
  Wait-state count lookup for external program, data and I/O accesses.
  Assumes the address and space are stable while wait_states is used.
*/
`timescale 1ns/10ps
`include "dag_regs.vh"
module dag_wait_sel (
  input wire [15:0] addr,
  input wire is_io,
  input wire [15:0] mem_wait_counts,
  input wire [15:0] io_wait_counts,
  input wire [15:0] wait_control,
  output reg [2:0] wait_states
);
  reg [1:0] field;
  reg [2:0] io_idx;
  always @* begin
    field = 2'h0;
    io_idx = 3'h0;
    if (is_io) begin
      if (wait_control[`DAG_WC_BIG_BIT]) begin
        io_idx = addr[15:13];
      end else begin
        io_idx = addr[3:1];
      end
      field = io_wait_counts[{io_idx, 1'b0} +: 2];
    end else begin
      field = mem_wait_counts[{addr[15:14], 1'b0} +: 2];
    end
    if (wait_control[`DAG_WC_SET_BIT] && field == 2'h2) begin
      wait_states = 3'h3;
    end else if (wait_control[`DAG_WC_SET_BIT] && field == 2'h3) begin
      wait_states = 3'h7;
    end else begin
      wait_states = {1'b0, field};
    end
  end
endmodule

// >>> rtl/dag_top.v
/*
  Local data address generator with its page-zero support registers,
  auxiliary register file, circular buffers, repeat and wait-state registers.
  Assumes decode presents one request per cycle, same clock, and that
  software does not write the single repeat count directly.
*/
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "dag_regs.vh"
module dag_top #(
  parameter SCRATCH_WORDS = 32
) (
  input wire core_clk,
  input wire reset,
  input wire op_valid,
  input wire [2:0] op_mode,
  input wire [6:0] op_offset,
  input wire op_second,
  input wire [15:0] pc_word,
  input wire [2:0] aux_arith_unit_op,
  input wire arp_load,
  input wire [2:0] arp_new,
  input wire page_load,
  input wire [8:0] page_new,
  input wire rpt_load,
  input wire [15:0] rpt_value,
  input wire repeat_block_op_load,
  input wire [15:0] repeat_block_op_start,
  input wire [15:0] repeat_block_op_end,
  input wire [6:0] wr_offset,
  input wire wr_en,
  input wire [15:0] wr_data,
  input wire [6:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [15:0] avs_writedata,
  output reg [15:0] avs_readdata,
  output wire avs_waitrequest,
  output reg [15:0] direct_addr_bus,
  output reg [15:0] aux_file_bus,
  output reg [15:0] first_data_addr_bus,
  output reg [15:0] program_addr_bus,
  output reg first_bus_valid,
  output reg program_bus_valid,
  output reg io_window_access,
  output reg [3:0] io_window_ports,
  output reg mmreg_access,
  output reg scratch_access,
  output reg [2:0] wait_states,
  output wire [8:0] page_pointer,
  output wire [2:0] aux_pointer,
  output wire [4:0] shift_count,
  output wire [3:0] bit_index,
  output wire [15:0] multiplicand_temp,
  output wire [15:0] global_overlay_reg,
  output wire [15:0] single_repeat_count,
  output wire [15:0] block_repeat_count,
  output wire [15:0] block_start_addr,
  output wire [15:0] block_end_addr
);
  reg [8:0] page_q;
  reg [2:0] arp_q;
  reg [15:0] aux_q [0:7];
  reg [15:0] index_q;
  reg [15:0] c1s_q, c1e_q, c2s_q, c2e_q;
  reg [7:0] cctl_q;
  reg [15:0] bmove_q, srep_q, brep_q, bstart_q, bend_q;
  reg [15:0] t0_q, t1_q, t2_q, glob_q;
  reg [15:0] mwait_q, iowait_q, wctl_q;
  reg [15:0] scratch_q [0:SCRATCH_WORDS-1];
  reg rd_done_q;
  reg [15:0] addr_d;
  reg [15:0] step_d;
  reg [2:0] ws_d;
  wire [15:0] cur_aux;
  wire [15:0] wrap1, wrap2;
  wire hit1, hit2;
  wire [2:0] ws_calc;
  wire [15:0] wr_offs_data;
  wire bus_wr;
  wire [6:0] wsel;
  wire [15:0] wdat;
  wire any_wr;
  integer i;

  assign page_pointer = page_q;
  assign aux_pointer = arp_q;
  assign cur_aux = aux_q[arp_q];
  assign shift_count = t1_q[4:0];
  assign bit_index = t2_q[3:0];
  assign multiplicand_temp = t0_q;
  assign global_overlay_reg = glob_q;
  assign single_repeat_count = srep_q;
  assign block_repeat_count = brep_q;
  assign block_start_addr = bstart_q;
  assign block_end_addr = bend_q;

  // Writes are taken at once; reads spend one cycle producing data.
  assign avs_waitrequest = avs_read && !rd_done_q;
  assign bus_wr = avs_write;
  assign any_wr = bus_wr || wr_en;
  assign wsel = bus_wr ? avs_address : wr_offset;
  assign wdat = bus_wr ? avs_writedata : wr_data;
  assign wr_offs_data = wdat;

  always @* begin
    case (aux_arith_unit_op)
      `DAG_AUX_ARITH_UNIT_INC: step_d = cur_aux + 16'h0001;
      `DAG_AUX_ARITH_UNIT_DEC: step_d = cur_aux - 16'h0001;
      `DAG_AUX_ARITH_UNIT_ADDX: step_d = cur_aux + index_q;
      `DAG_AUX_ARITH_UNIT_SUBX: step_d = cur_aux - index_q;
      default: step_d = cur_aux;
    endcase
  end

  dag_circ_unit u_circ1 (
    .enable(cctl_q[`DAG_CC_EN1_BIT]),
    .aux_sel(arp_q),
    .buf_aux(cctl_q[`DAG_CC_CAR1_LSB +: 3]),
    .cur_val(cur_aux),
    .step_val(step_d),
    .start_addr(c1s_q),
    .end_addr(c1e_q),
    .hit(hit1),
    .wrapped(wrap1)
  );

  dag_circ_unit u_circ2 (
    .enable(cctl_q[`DAG_CC_EN2_BIT]),
    .aux_sel(arp_q),
    .buf_aux(cctl_q[`DAG_CC_CAR2_LSB +: 3]),
    .cur_val(cur_aux),
    .step_val(step_d),
    .start_addr(c2s_q),
    .end_addr(c2e_q),
    .hit(hit2),
    .wrapped(wrap2)
  );

  always @* begin
    case (op_mode)
      `DAG_MODE_DIRECT: addr_d = {page_q, op_offset};
      `DAG_MODE_MMAP: addr_d = {9'h000, op_offset};
      `DAG_MODE_INDIRECT: addr_d = cur_aux;
      `DAG_MODE_LONG: addr_d = pc_word;
      `DAG_MODE_BLOCK: addr_d = bmove_q;
      default: addr_d = {page_q, op_offset};
    endcase
  end

  wire win_io = (addr_d[15:7] == 9'h000) && (addr_d[6:0] >= `DAG_OFS_IO_FIRST) &&
    (addr_d[6:0] <= `DAG_OFS_IO_LAST);

  dag_wait_sel u_wait (
    .addr(win_io ? {12'h000, addr_d[3:0]} : addr_d),
    .is_io(win_io),
    .mem_wait_counts(mwait_q),
    .io_wait_counts(iowait_q),
    .wait_control(wctl_q),
    .wait_states(ws_calc)
  );

  always @* begin
    ws_d = ws_calc;
  end

  // Address outputs and page-zero decode, registered.
  always @(posedge core_clk) begin
    if (reset) begin
      direct_addr_bus <= `DAG_RST_WORD;
      aux_file_bus <= `DAG_RST_WORD;
      first_data_addr_bus <= `DAG_RST_WORD;
      program_addr_bus <= `DAG_RST_WORD;
      first_bus_valid <= 1'b0;
      program_bus_valid <= 1'b0;
      io_window_access <= 1'b0;
      io_window_ports <= 4'h0;
      mmreg_access <= 1'b0;
      scratch_access <= 1'b0;
      wait_states <= 3'h0;
    end else begin
      first_bus_valid <= op_valid && !op_second;
      program_bus_valid <= op_valid && op_second;
      io_window_access <= op_valid && win_io;
      io_window_ports <= addr_d[3:0];
      mmreg_access <= op_valid && addr_d[15:7] == 9'h000 &&
        addr_d[6:0] <= `DAG_OFS_REG_LAST;
      scratch_access <= op_valid && addr_d[15:7] == 9'h000 &&
        addr_d[6:0] >= `DAG_OFS_SCR_FIRST;
      wait_states <= ws_d;
      if (op_valid) begin
        if (op_mode == `DAG_MODE_DIRECT || op_mode == `DAG_MODE_MMAP) begin
          direct_addr_bus <= addr_d;
        end
        if (op_mode == `DAG_MODE_INDIRECT) begin
          aux_file_bus <= addr_d;
        end
        if (op_second) begin
          program_addr_bus <= addr_d;
        end else begin
          first_data_addr_bus <= addr_d;
        end
      end
    end
  end

  // Register file: decode hooks, memory-mapped writes and the aux unit.
  always @(posedge core_clk) begin
    if (reset) begin
      page_q <= 9'h000;
      arp_q <= 3'h0;
      for (i = 0; i < 8; i = i + 1) begin
        aux_q[i] <= `DAG_RST_WORD;
      end
      index_q <= `DAG_RST_WORD;
      c1s_q <= `DAG_RST_WORD;
      c1e_q <= `DAG_RST_WORD;
      c2s_q <= `DAG_RST_WORD;
      c2e_q <= `DAG_RST_WORD;
      cctl_q <= 8'h00;
      bmove_q <= `DAG_RST_WORD;
      srep_q <= `DAG_RST_WORD;
      brep_q <= `DAG_RST_WORD;
      bstart_q <= `DAG_RST_WORD;
      bend_q <= `DAG_RST_WORD;
      t0_q <= `DAG_RST_WORD;
      t1_q <= `DAG_RST_WORD;
      t2_q <= `DAG_RST_WORD;
      glob_q <= `DAG_RST_WORD;
      mwait_q <= `DAG_RST_WAIT;
      iowait_q <= `DAG_RST_WAIT;
      wctl_q <= `DAG_RST_WAITCTL;
      rd_done_q <= 1'b0;
    end else begin
      rd_done_q <= avs_read && !rd_done_q;
      if (page_load) begin
        page_q <= page_new;
      end
      if (any_wr) begin
        case (wsel)
          `DAG_OFS_GLOBAL: glob_q <= wr_offs_data;
          `DAG_OFS_SREP: srep_q <= wr_offs_data;
          `DAG_OFS_BREP: brep_q <= wr_offs_data;
          `DAG_OFS_BSTART: bstart_q <= wr_offs_data;
          `DAG_OFS_BEND: bend_q <= wr_offs_data;
          `DAG_OFS_TEMP0: t0_q <= wr_offs_data;
          `DAG_OFS_TEMP1: t1_q <= wr_offs_data;
          `DAG_OFS_TEMP2: t2_q <= wr_offs_data;
          `DAG_OFS_INDEX: index_q <= wr_offs_data;
          `DAG_OFS_C1START: c1s_q <= wr_offs_data;
          `DAG_OFS_C1END: c1e_q <= wr_offs_data;
          `DAG_OFS_C2START: c2s_q <= wr_offs_data;
          `DAG_OFS_C2END: c2e_q <= wr_offs_data;
          `DAG_OFS_CCTRL: cctl_q <= wr_offs_data[7:0];
          `DAG_OFS_BMOVE: bmove_q <= wr_offs_data;
          `DAG_OFS_MEMWAIT: mwait_q <= wr_offs_data;
          `DAG_OFS_IOWAIT: iowait_q <= wr_offs_data;
          `DAG_OFS_WAITCTL: wctl_q <= {14'h0000, wr_offs_data[1:0]};
          default: begin
            if (wsel[6:3] == 4'h2) begin
              aux_q[wsel[2:0]] <= wr_offs_data;
            end
          end
        endcase
      end
      // Decode-driven loads take priority over software writes.
      if (rpt_load) begin
        srep_q <= rpt_value;
      end
      if (repeat_block_op_load) begin
        bstart_q <= repeat_block_op_start;
        bend_q <= repeat_block_op_end;
      end
      // The modified value lands after the current access has used the old one.
      if (op_valid && op_mode == `DAG_MODE_INDIRECT && aux_arith_unit_op != `DAG_AUX_ARITH_UNIT_NONE) begin
        aux_q[arp_q] <= hit1 ? wrap1 : (hit2 ? wrap2 : step_d);
      end
      if (arp_load) begin
        arp_q <= arp_new;
      end
    end
  end

  // Scratch RAM lives at 60h-7Fh of page zero.
  always @(posedge core_clk) begin
    if (any_wr && wsel >= `DAG_OFS_SCR_FIRST) begin
      scratch_q[wsel[4:0]] <= wdat;
    end
  end

  always @(posedge core_clk) begin
    if (reset) begin
      avs_readdata <= `DAG_RST_WORD;
    end else if (avs_read && !rd_done_q) begin
      if (avs_address >= `DAG_OFS_SCR_FIRST) begin
        avs_readdata <= scratch_q[avs_address[4:0]];
      end else if (avs_address[6:3] == 4'h2) begin
        avs_readdata <= aux_q[avs_address[2:0]];
      end else begin
        case (avs_address)
          `DAG_OFS_GLOBAL: avs_readdata <= glob_q;
          `DAG_OFS_SREP: avs_readdata <= srep_q;
          `DAG_OFS_BREP: avs_readdata <= brep_q;
          `DAG_OFS_BSTART: avs_readdata <= bstart_q;
          `DAG_OFS_BEND: avs_readdata <= bend_q;
          `DAG_OFS_TEMP0: avs_readdata <= t0_q;
          `DAG_OFS_TEMP1: avs_readdata <= t1_q;
          `DAG_OFS_TEMP2: avs_readdata <= t2_q;
          `DAG_OFS_INDEX: avs_readdata <= index_q;
          `DAG_OFS_C1START: avs_readdata <= c1s_q;
          `DAG_OFS_C1END: avs_readdata <= c1e_q;
          `DAG_OFS_C2START: avs_readdata <= c2s_q;
          `DAG_OFS_C2END: avs_readdata <= c2e_q;
          `DAG_OFS_CCTRL: avs_readdata <= {8'h00, cctl_q};
          `DAG_OFS_BMOVE: avs_readdata <= bmove_q;
          `DAG_OFS_MEMWAIT: avs_readdata <= mwait_q;
          `DAG_OFS_IOWAIT: avs_readdata <= iowait_q;
          `DAG_OFS_WAITCTL: avs_readdata <= wctl_q;
          default: avs_readdata <= `DAG_RST_WORD;
        endcase
      end
    end
  end
endmodule

// >>> tb/dag_monitor.sv
/*
  Port checker for the data address generator top module.
  Assumes it is bound to dag_top and sees its ports only.
*/
`timescale 1ns/10ps
`include "dag_regs.vh"
module dag_monitor (
  input wire core_clk,
  input wire reset,
  input wire op_valid,
  input wire [2:0] op_mode,
  input wire [6:0] op_offset,
  input wire op_second,
  input wire [15:0] pc_word,
  input wire page_load,
  input wire [8:0] page_new,
  input wire rpt_load,
  input wire [15:0] rpt_value,
  input wire [15:0] direct_addr_bus,
  input wire [15:0] program_addr_bus,
  input wire first_bus_valid,
  input wire program_bus_valid,
  input wire io_window_access,
  input wire [3:0] io_window_ports,
  input wire mmreg_access,
  input wire [8:0] page_pointer,
  input wire [15:0] single_repeat_count
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_req(m, c);
    op_valid && op_mode == m && c;
  endsequence
  direct_addr_a: assert property (s_req(`DAG_MODE_DIRECT, 1'b1) |=>
    direct_addr_bus == {$past(page_pointer), $past(op_offset)}) else $error("direct address");
  mmap_addr_a: assert property (s_req(`DAG_MODE_MMAP, 1'b1) |=>
    direct_addr_bus == {9'h000, $past(op_offset)}) else $error("mmap address");
  page_load_a: assert property (page_load |=> page_pointer == $past(page_new))
    else $error("page pointer load");
  first_bus_a: assert property (op_valid && !op_second |=>
    first_bus_valid && !program_bus_valid) else $error("first bus valid");
  long_addr_a: assert property (s_req(`DAG_MODE_LONG, op_second) |=>
    program_bus_valid && program_addr_bus == $past(pc_word)) else $error("long address");
  io_window_a: assert property (s_req(`DAG_MODE_MMAP, op_offset[6:4] == 3'h5) |=>
    io_window_access && io_window_ports == $past(op_offset[3:0])) else $error("io window");
  mmreg_dec_a: assert property (s_req(`DAG_MODE_MMAP, op_offset <= 7'h4f) |=>
    mmreg_access && !io_window_access) else $error("register decode");
  rpt_load_a: assert property (rpt_load |=> single_repeat_count == $past(rpt_value))
    else $error("repeat count load");
endmodule
bind dag_top dag_monitor mon_u (.core_clk, .reset, .op_valid, .op_mode, .op_offset, .op_second,
  .pc_word, .page_load, .page_new, .rpt_load, .rpt_value, .direct_addr_bus, .program_addr_bus,
  .first_bus_valid, .program_bus_valid, .io_window_access, .io_window_ports, .mmreg_access,
  .page_pointer, .single_repeat_count);

// >>> tb/dag_mem_model.sv
/*
  Far-side memory model: counts address cycles presented on either bus.
  Assumes the buses are valid only while their valid flags are high.
*/
`timescale 1ns/10ps
module dag_mem_model (
  input wire core_clk,
  input wire reset,
  input wire first_bus_valid,
  input wire program_bus_valid,
  input wire [15:0] first_data_addr_bus,
  output reg [15:0] hits
);
  reg [15:0] last_addr_q;
  always @(posedge core_clk) begin
    if (reset) begin
      hits <= 16'h0000;
    end else if (first_bus_valid || program_bus_valid) begin
      hits <= hits + 16'h0001;
      last_addr_q <= first_data_addr_bus;
    end
  end
endmodule

// >>> tb/testbench.sv
/*
  Self-checking bench for dag_top: queue of expected results, output monitor.
  Assumes one clock and Avalon-MM register access.
*/
`timescale 1ns/10ps
`include "dag_regs.vh"
module testbench;
  reg core_clk = 0, reset = 1, op_valid = 0, op_second = 0, arp_load = 0, page_load = 0;
  reg rpt_load = 0, repeat_block_op_load = 0, wr_en = 0, avs_read = 0, avs_write = 0;
  reg [2:0] op_mode = 0, aux_arith_unit_op = 0, arp_new = 0;
  reg [6:0] op_offset = 0, wr_offset = 0, avs_address = 0;
  reg [8:0] page_new = 0;
  reg [15:0] pc_word = 0, rpt_value = 0, repeat_block_op_start = 0, repeat_block_op_end = 0, wr_data = 0;
  reg [15:0] avs_writedata = 0, a, s, x;
  wire [15:0] avs_readdata, direct_addr_bus, aux_file_bus, first_data_addr_bus, hits;
  wire [15:0] program_addr_bus, multiplicand_temp, global_overlay_reg, single_repeat_count;
  wire [15:0] block_repeat_count, block_start_addr, block_end_addr;
  wire avs_waitrequest, first_bus_valid, program_bus_valid, io_window_access, mmreg_access;
  wire scratch_access;
  wire [3:0] io_window_ports, bit_index;
  wire [2:0] wait_states, aux_pointer;
  wire [8:0] page_pointer;
  wire [4:0] shift_count;
  integer n_mismatch = 0, compares = 0, n_ops = 0, i, j;
  reg [31:0] rng = 32'd37796;
  reg [18:0] nt;
  reg [18:0] notes[$];
  reg [15:0] vals[0:10];
  localparam [76:0] REG_TBL = {`DAG_OFS_BMOVE, `DAG_OFS_C2END, `DAG_OFS_C2START,
    `DAG_OFS_C1END, `DAG_OFS_C1START, `DAG_OFS_INDEX, `DAG_OFS_TEMP0, `DAG_OFS_BEND,
    `DAG_OFS_BSTART, `DAG_OFS_BREP, `DAG_OFS_GLOBAL};
  localparam [48:0] MM_TBL = {7'h05, 7'h7f, 7'h60, 7'h5f, 7'h5a, 7'h50, 7'h4f};
  dag_top dut_u (.core_clk, .reset, .op_valid, .op_mode, .op_offset, .op_second, .pc_word,
    .aux_arith_unit_op, .arp_load, .arp_new, .page_load, .page_new, .rpt_load, .rpt_value, .repeat_block_op_load,
    .repeat_block_op_start, .repeat_block_op_end, .wr_offset, .wr_en, .wr_data, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .direct_addr_bus, .aux_file_bus,
    .first_data_addr_bus, .program_addr_bus, .first_bus_valid, .program_bus_valid,
    .io_window_access, .io_window_ports, .mmreg_access, .scratch_access, .wait_states,
    .page_pointer, .aux_pointer, .shift_count, .bit_index, .multiplicand_temp,
    .global_overlay_reg, .single_repeat_count, .block_repeat_count, .block_start_addr,
    .block_end_addr);
  dag_mem_model mem_u (.core_clk, .reset, .first_bus_valid, .program_bus_valid,
    .first_data_addr_bus, .hits);
  always #25 core_clk = ~core_clk;
  function [15:0] rnd(input dummy);
    begin
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      rnd = rng[15:0];
    end
  endfunction
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task bus(input wr, input [6:0] ad, input [15:0] d);
    begin
      @(posedge core_clk);
      avs_address <= ad;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      if (!wr) notes.push_back({3'h3, d});
      @(posedge core_clk);
      // The request stands until an edge samples waitrequest low; the watchdog ends a hang.
      while (avs_waitrequest !== 1'b0) begin
        @(posedge core_clk);
      end
      avs_write <= 0;
      avs_read <= 0;
    end
  endtask
  task op(input [2:0] m, input [6:0] o, input [2:0] ar, input [2:0] kind, input [15:0] e);
    begin
      @(posedge core_clk);
      op_valid <= 1;
      op_mode <= m;
      op_offset <= o;
      aux_arith_unit_op <= ar;
      op_second <= (m >= `DAG_MODE_LONG);
      notes.push_back({kind, e});
      n_ops = n_ops + 1;
    end
  endtask
  task idle;
    begin
      @(posedge core_clk);
      op_valid <= 0;
    end
  endtask
  task setpage(input [8:0] p);
    begin
      @(posedge core_clk);
      page_load <= 1;
      page_new <= p;
      @(posedge core_clk);
      page_load <= 0;
    end
  endtask
  always @(negedge core_clk) begin
    if (!reset && (first_bus_valid === 1'b1 || program_bus_valid === 1'b1 ||
        (avs_read && avs_waitrequest === 1'b0))) begin
      nt = (notes.size() > 0) ? notes.pop_front() : 19'h7ffff;
      case (nt[18:16])
        3'h0: begin
          chk(direct_addr_bus, nt[15:0]);
          chk(first_data_addr_bus, nt[15:0]);
        end
        3'h1: chk(aux_file_bus, nt[15:0]);
        3'h2: chk(program_addr_bus, nt[15:0]);
        3'h3: chk(avs_readdata, nt[15:0]);
        3'h4: chk({9'h0, io_window_access, mmreg_access, scratch_access, io_window_ports},
          nt[15:0]);
        3'h5: chk({13'h0, wait_states}, nt[15:0]);
        default: chk(16'hdead, 16'h0000);
      endcase
    end
  end
  initial begin
    #400000;
    n_mismatch = n_mismatch + 1;
    end_of_test;
  end
  initial begin
    repeat (4) @(posedge core_clk);
    reset <= 0;
    bus(0, `DAG_OFS_WAITCTL, 16'h0000);
    bus(0, `DAG_OFS_MEMWAIT, 16'hffff);
    bus(0, `DAG_OFS_IOWAIT, 16'hffff);
    bus(1, 7'h03, 16'h1234);
    bus(0, 7'h03, 16'h0000);
    bus(1, 7'h65, 16'hbeef);
    bus(0, 7'h65, 16'hbeef);
    for (i = 0; i < 11; i = i + 1) begin
      vals[i] = rnd(0);
      bus(1, REG_TBL[i*7 +: 7], vals[i]);
      bus(0, REG_TBL[i*7 +: 7], vals[i]);
    end
    chk(global_overlay_reg, vals[0]);
    chk(block_repeat_count, vals[1]);
    bus(1, `DAG_OFS_TEMP1, 16'h001b);
    bus(1, `DAG_OFS_TEMP2, 16'h000d);
    @(negedge core_clk);
    chk({11'h0, shift_count}, 16'h001b);
    chk({12'h0, bit_index}, 16'h000d);
    @(posedge core_clk);
    wr_en <= 1;
    wr_offset <= `DAG_OFS_TEMP0;
    wr_data <= 16'h5a3c;
    rpt_load <= 1;
    rpt_value <= rnd(0);
    repeat_block_op_load <= 1;
    repeat_block_op_start <= rnd(0);
    repeat_block_op_end <= rnd(0);
    @(posedge core_clk);
    wr_en <= 0;
    rpt_load <= 0;
    repeat_block_op_load <= 0;
    @(negedge core_clk);
    chk(multiplicand_temp, 16'h5a3c);
    chk(single_repeat_count, rpt_value);
    chk(block_start_addr, repeat_block_op_start);
    chk(block_end_addr, repeat_block_op_end);
    $display("test registers done");
    setpage(9'h18d);
    op(`DAG_MODE_DIRECT, 7'h00, 0, 0, 16'hc680);
    idle;
    for (i = 0; i < 4; i = i + 1) begin
      x = (i == 3) ? 16'hffff : rnd(0);
      setpage(x[8:0]);
      op(`DAG_MODE_DIRECT, x[15:9], 0, 0, {x[8:0], x[15:9]});
      idle;
    end
    op(`DAG_MODE_MMAP, 7'h07, 0, 0, 16'h0007);
    for (i = 0; i < 7; i = i + 1)
      op(`DAG_MODE_MMAP, MM_TBL[i*7 +: 7], 0, 4, {((MM_TBL[i*7 +: 7] <= 7'h4f) ? 12'h002 :
        (MM_TBL[i*7 +: 7] <= 7'h5f) ? 12'h004 : 12'h001), MM_TBL[i*7 +: 4]});
    x = rnd(0);
    pc_word <= x;
    op(`DAG_MODE_LONG, 7'h00, 0, 2, x);
    op(`DAG_MODE_BLOCK, 7'h00, 0, 2, vals[10]);
    idle;
    $display("test direct modes done");
    a = rnd(0);
    x = vals[5];
    bus(1, `DAG_OFS_AUX0 + 7'h3, a);
    @(posedge core_clk);
    arp_load <= 1;
    arp_new <= 3'h3;
    @(posedge core_clk);
    arp_load <= 0;
    op(`DAG_MODE_INDIRECT, 0, `DAG_AUX_ARITH_UNIT_INC, 1, a);
    op(`DAG_MODE_INDIRECT, 0, `DAG_AUX_ARITH_UNIT_DEC, 1, a + 16'h1);
    op(`DAG_MODE_INDIRECT, 0, `DAG_AUX_ARITH_UNIT_ADDX, 1, a);
    op(`DAG_MODE_INDIRECT, 0, `DAG_AUX_ARITH_UNIT_SUBX, 1, a + x);
    op(`DAG_MODE_INDIRECT, 0, `DAG_AUX_ARITH_UNIT_NONE, 1, a);
    idle;
    chk({13'h0, aux_pointer}, 16'h0003);
    for (j = 0; j < 2; j = j + 1) begin
      s = rnd(0);
      bus(1, j ? `DAG_OFS_C2START : `DAG_OFS_C1START, s);
      bus(1, j ? `DAG_OFS_C2END : `DAG_OFS_C1END, s + 16'h8);
      bus(1, `DAG_OFS_CCTRL, j ? 16'h00b0 : 16'h000b);
      bus(1, `DAG_OFS_AUX0 + 7'h3, s + 16'h8);
      op(`DAG_MODE_INDIRECT, 0, `DAG_AUX_ARITH_UNIT_INC, 1, s + 16'h8);
      op(`DAG_MODE_INDIRECT, 0, `DAG_AUX_ARITH_UNIT_INC, 1, s);
      op(`DAG_MODE_INDIRECT, 0, `DAG_AUX_ARITH_UNIT_NONE, 1, s + 16'h1);
      idle;
      bus(1, `DAG_OFS_CCTRL, 16'h0000);
    end
    $display("test indirect done");
    setpage(9'h180);
    for (j = 0; j < 2; j = j + 1) begin
      bus(1, `DAG_OFS_WAITCTL, j);
      for (i = 0; i < 4; i = i + 1) begin
        bus(1, `DAG_OFS_MEMWAIT, i << 6);
        op(`DAG_MODE_DIRECT, 7'h00, 0, 5, j ? (16'h1 << i) - 16'h1 : i);
        idle;
      end
    end
    bus(1, `DAG_OFS_IOWAIT, 16'h0008);
    bus(1, `DAG_OFS_WAITCTL, 16'h0000);
    op(`DAG_MODE_MMAP, 7'h52, 0, 5, 16'h0002);
    idle;
    bus(1, `DAG_OFS_WAITCTL, 16'h0002);
    op(`DAG_MODE_MMAP, 7'h52, 0, 5, 16'h0000);
    idle;
    $display("test wait states done");
    repeat (3) @(posedge core_clk);
    chk(hits, n_ops[15:0]);
    chk(notes.size(), 16'h0000);
    end_of_test;
  end
endmodule
